// ===== design/crs_pkg.sv
/*
  Package of the common register synchronizer: register map, timing
  constants, request carrier and state encoding.
  Assumes a single system clock of 125 MHz; the core clock is sampled.
*/
`default_nettype none
package crs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned    NUM_REGS        = 8;     // Register slots
  localparam int unsigned    ADDR_W          = 3;     // Register index width
  localparam int unsigned    DATA_W          = 32;    // Register width
  localparam logic [2:0]     FIRST_CORE_REG  = 3'h2;  // Index 0..1 live in bus domain
  localparam logic [2:0]     FIRST_RSYNC_REG = 3'h6;  // Index 6..7 are read-synchronized
  localparam logic [31:0]    REG_RESET_VAL   = 32'h0000_0000; // Value after reset

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned    SYS_CLK_MHZ     = 125;   // System clock rate
  localparam int unsigned    CORE_EDGES      = 6;     // Core edges per crossing
  localparam logic [2:0]     EDGE_CNT_RESET  = 3'h0;  // Edge counter after reset

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              write;  // 1 = write, 0 = read
    logic [ADDR_W-1:0] index;  // Register index
    logic [DATA_W-1:0] wdata;  // Write data
  } crs_req_s;

  typedef enum logic [1:0] {
    CRS_IDLE,                  // No crossing in flight
    CRS_WSYNC,                 // Write crossing in flight, bus released
    CRS_RSYNC                  // Read crossing in flight, bus stalled
  } crs_state_e;

endpackage
`default_nettype wire

// ===== design/crs_sync.sv
/*
  Common register synchronizer. One crossing engine serves every core
  register; bus-domain registers are reached directly.
  Assumes the bus master holds its request until bus_ready_o pulses and
  drops it in the cycle after. The core clock arrives as a plain input and
  is sampled by two flip-flops; its edges pace the crossing.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_sync (
  input  wire logic                       sys_clk_i,                  // Bus clock, 125 MHz
  input  wire logic                       rst_b_i,                    // Async reset, active low
  input  wire logic                       peripheral_core_clock_i,    // Core clock, sampled
  input  wire logic                       bus_req_i,                  // Request pending
  input  wire crs_pkg::crs_req_s          bus_cmd_i,                  // Request contents
  input  wire logic [crs_pkg::DATA_W-1:0] core_rsync_val_i [2],       // Core-domain live values
  output logic                            bus_ready_o,                // Request done pulse
  output logic      [crs_pkg::DATA_W-1:0] bus_rdata_o,                // Read data
  output logic                            sync_in_progress_o,         // Write crossing busy
  output logic      [crs_pkg::DATA_W-1:0] core_reg_o [crs_pkg::NUM_REGS] // Registers as seen by core
);
  import crs_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [2:0]        clk_pipe;                  // Core clock sampler, bit 0 first
  logic              core_edge;                 // Core rising edge seen
  logic [DATA_W-1:0] rs_meta  [2];              // First sampler stage
  logic [DATA_W-1:0] rs_sync  [2];              // Second sampler stage
  crs_state_e        state;                     // Crossing engine state
  logic [2:0]        edge_cnt;                  // Core edges in this crossing
  logic              cross_done;                // Crossing completes this cycle
  logic [ADDR_W-1:0] sync_index;                // Register under crossing
  logic [DATA_W-1:0] sync_data;                 // Data being carried across
  logic [DATA_W-1:0] shadow   [NUM_REGS];       // Bus-side copies
  logic              take;                      // Request may be examined
  logic              is_core;                   // Request targets core domain
  logic              is_rsync;                  // Request targets read-sync register
  logic              start_w;                   // Begin write crossing
  logic              start_r;                   // Begin read crossing
  logic              answer_now;                // Complete request this cycle

  // ----------------------------------------------------------------------
  // Core clock sampling
  // ----------------------------------------------------------------------
  // Two flops before use; the third only delays for the edge compare
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_pipe <= 3'h0;
    end else begin
      clk_pipe <= {clk_pipe[1:0], peripheral_core_clock_i};
    end
  end

  assign core_edge = clk_pipe[1] & ~clk_pipe[2];

  // Core live values: quasi-static while read, so a plain two-flop
  // sampler per word is enough; captured only after several core edges
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rs
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          rs_meta[g] <= REG_RESET_VAL;
          rs_sync[g] <= REG_RESET_VAL;
        end else begin
          rs_meta[g] <= core_rsync_val_i[g];
          rs_sync[g] <= rs_meta[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  // Ready high blocks a second take of the same request
  assign take     = bus_req_i & ~bus_ready_o;
  assign is_core  = (bus_cmd_i.index >= FIRST_CORE_REG);
  assign is_rsync = (bus_cmd_i.index >= FIRST_RSYNC_REG);

  // Only one crossing at a time, so any core write waits for idle
  assign start_w = take & (state == CRS_IDLE) & bus_cmd_i.write & is_core;
  // Read-sync read waits out a write crossing, then runs its own
  assign start_r = take & (state == CRS_IDLE) & ~bus_cmd_i.write & is_rsync;

  // Direct answers: bus registers always, plain core reads unless the
  // register is the one being written
  always_comb begin
    answer_now = 1'b0;
    if (take) begin
      if (!is_core) begin
        answer_now = 1'b1;
      end else if (bus_cmd_i.write) begin
        answer_now = start_w;
      end else if (!is_rsync) begin
        answer_now = !((state == CRS_WSYNC) && (sync_index == bus_cmd_i.index));
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossing engine
  // ----------------------------------------------------------------------
  // Done on the sixth sampled core edge: 5..6 core periods after start
  // plus the 2..3 bus cycles of sampling latency
  assign cross_done = (state != CRS_IDLE) & core_edge &
                      (edge_cnt == 3'(CORE_EDGES - 1));

  // State: engine runs even with identical clocks, no bypass path
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= CRS_IDLE;
    end else begin
      case (state)
        CRS_IDLE: begin
          if (start_w) begin
            state <= CRS_WSYNC;
          end else if (start_r) begin
            state <= CRS_RSYNC;
          end
        end
        CRS_WSYNC, CRS_RSYNC: begin
          if (cross_done) begin
            state <= CRS_IDLE;
          end
        end
        default: begin
          state <= CRS_IDLE;
        end
      endcase
    end
  end

  // Edge counter, cleared at each start
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_cnt <= EDGE_CNT_RESET;
    end else if (start_w || start_r || cross_done) begin
      edge_cnt <= EDGE_CNT_RESET;
    end else if ((state != CRS_IDLE) && core_edge) begin
      edge_cnt <= edge_cnt + 3'h1;
    end
  end

  // Latched target and payload
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_index <= '0;
      sync_data  <= REG_RESET_VAL;
    end else if (start_w || start_r) begin
      sync_index <= bus_cmd_i.index;
      sync_data  <= bus_cmd_i.wdata;
    end
  end

  // Busy flag: write crossings only; drops as the crossing lands on the sixth sampled core edge
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_in_progress_o <= 1'b0;
    end else if (start_w) begin
      sync_in_progress_o <= 1'b1;
    end else if (cross_done && (state == CRS_WSYNC)) begin
      sync_in_progress_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  // Bus registers written directly; core registers only when the crossing
  // lands, so core and shadow copies always agree
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          shadow[g]     <= REG_RESET_VAL;
          core_reg_o[g] <= REG_RESET_VAL;
        end else if (g < FIRST_CORE_REG) begin
          if (take && bus_cmd_i.write && (bus_cmd_i.index == ADDR_W'(g))) begin
            shadow[g]     <= bus_cmd_i.wdata;
            core_reg_o[g] <= bus_cmd_i.wdata;
          end
        end else if (cross_done && (state == CRS_WSYNC) && (sync_index == ADDR_W'(g))) begin
          shadow[g]     <= sync_data;
          core_reg_o[g] <= sync_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  // Ready is low while stalled; a read crossing answers when it lands
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_ready_o <= 1'b0;
      bus_rdata_o <= REG_RESET_VAL;
    end else if (cross_done && (state == CRS_RSYNC)) begin
      bus_ready_o <= 1'b1;
      bus_rdata_o <= rs_sync[sync_index[0]];
    end else if (answer_now) begin
      bus_ready_o <= 1'b1;
      bus_rdata_o <= bus_cmd_i.write ? REG_RESET_VAL : shadow[bus_cmd_i.index];
    end else begin
      bus_ready_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/crs_sync_checker.sv
/* Port checker of the register synchronizer.
   Assumes a core clock period of CP bus clock cycles. */
`timescale 1ns/1ps
`default_nettype none
module crs_sync_checker import crs_pkg::*; #(
  parameter int CP = 5                                   // Core period, bus cycles
) (
  input wire logic              sys_clk_i,               // Bus clock
  input wire logic              rst_b_i,                 // Reset, active low
  input wire logic              bus_req_i,               // Request pending
  input wire crs_req_s          bus_cmd_i,               // Request contents
  input wire logic              bus_ready_o,             // Answer pulse
  input wire logic              sync_in_progress_o,      // Write crossing busy
  input wire logic [DATA_W-1:0] core_reg_o [NUM_REGS]    // Core view
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic              tk, wr, core, rs;                   // Request decode
  logic [ADDR_W-1:0] last_idx;                           // Last core write index
  logic [DATA_W-1:0] last_dat;                           // Last core write data
  logic [7:0]        busy_len;                           // Busy cycles so far
  assign tk   = bus_req_i && !bus_ready_o;
  assign wr   = bus_cmd_i.write;
  assign core = bus_cmd_i.index >= FIRST_CORE_REG;
  assign rs   = bus_cmd_i.index >= FIRST_RSYNC_REG;
  // A core write is answered as its crossing starts
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_idx <= '0;
      last_dat <= '0;
    end else if (bus_ready_o && wr && core) begin
      last_idx <= bus_cmd_i.index;
      last_dat <= bus_cmd_i.wdata;
    end
  end
  // Length of the busy window, read back as it closes
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_len <= 8'h00;
    end else begin
      busy_len <= sync_in_progress_o ? busy_len + 8'h01 : 8'h00;
    end
  end
  property p_pulse; bus_ready_o |=> !bus_ready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_direct; tk && !core |=> bus_ready_o; endproperty
  a_direct: assert property (p_direct) else $error("bus reg stalled");
  property p_start; tk && wr && core && !sync_in_progress_o |=> bus_ready_o && sync_in_progress_o; endproperty
  a_start: assert property (p_start) else $error("write did not start");
  property p_wait; tk && wr && core && sync_in_progress_o |=> !bus_ready_o; endproperty
  a_wait: assert property (p_wait) else $error("write not held");
  property p_same; tk && !wr && bus_cmd_i.index == last_idx && sync_in_progress_o |=> !bus_ready_o; endproperty
  a_same: assert property (p_same) else $error("read of busy reg not held");
  property p_shadow; tk && !wr && core && !rs && bus_cmd_i.index != last_idx |=> bus_ready_o; endproperty
  a_shadow: assert property (p_shadow) else $error("shadow read stalled");
  property p_rsync; $rose(bus_req_i) && !wr && rs |=> !bus_ready_o [*8]; endproperty
  a_rsync: assert property (p_rsync) else $error("synced read too fast");
  property p_rflag; $rose(bus_req_i) && !wr && rs && !sync_in_progress_o |=> !sync_in_progress_o [*8]; endproperty
  a_rflag: assert property (p_rflag) else $error("read set busy");
  property p_dur; !sync_in_progress_o && busy_len != 0 |-> busy_len >= 5*CP-1 && busy_len <= 6*CP+3; endproperty
  a_dur: assert property (p_dur) else $error("crossing length off");
  property p_land; $fell(sync_in_progress_o) |-> core_reg_o[last_idx] == last_dat; endproperty
  a_land: assert property (p_land) else $error("write did not land");
  c_wait: cover property (tk && wr && core && sync_in_progress_o);
  c_rsync: cover property ($rose(bus_req_i) && !wr && rs);
  c_land: cover property ($fell(sync_in_progress_o));
endmodule
bind crs_sync crs_sync_checker crs_sync_checker_i (.sys_clk_i, .rst_b_i, .bus_req_i, .bus_cmd_i,
  .bus_ready_o, .sync_in_progress_o, .core_reg_o);
`default_nettype wire

// ===== testbench/crs_core_model.sv
/* Core side model: free core clock and live values of the read-synced regs.
   Values stay stable, as the crossing needs. */
`timescale 1ns/1ps
`default_nettype none
module crs_core_model import crs_pkg::*; #(
  parameter logic [DATA_W-1:0] V6 = 32'h0000_0006,     // Live value, reg 6
  parameter logic [DATA_W-1:0] V7 = 32'h0000_0007      // Live value, reg 7
) (
  output var logic              clk_o,                 // Core clock, 40 ns
  output var logic [DATA_W-1:0] val_o [2]              // Live values
);
  // Phase offset keeps the core edges apart from the bus edges
  initial begin
    val_o[0] = V6;
    val_o[1] = V7;
    clk_o = 1'b0;
    #3;
    forever #20 clk_o = ~clk_o;
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
/* Self-checking bench of the register synchronizer.
   Assumes the core model runs at 5 bus cycles per core period. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  checks++; \
  if ((a) !== (e)) begin \
    num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module tb;
  import crs_pkg::*;
  localparam int          CP = 5;                 // Core period, bus cycles
  localparam logic [31:0] V6 = 32'h6a6a_0606;     // Core value, reg 6
  localparam logic [31:0] V7 = 32'h7b7b_0707;     // Core value, reg 7
  logic sys_clk_i, rst_b_i, peripheral_core_clock_i, bus_req_i, bus_ready_o, sync_in_progress_o;
  crs_req_s          bus_cmd_i;
  logic [DATA_W-1:0] core_rsync_val_i [2];
  logic [DATA_W-1:0] bus_rdata_o;
  logic [DATA_W-1:0] core_reg_o [NUM_REGS];
  int num_errors = 0;
  int checks = 0;
  int ns;
  crs_sync crs_sync_i (.sys_clk_i, .rst_b_i, .peripheral_core_clock_i, .bus_req_i, .bus_cmd_i,
    .core_rsync_val_i, .bus_ready_o, .bus_rdata_o, .sync_in_progress_o, .core_reg_o);
  crs_core_model #(.V6(V6), .V7(V7)) crs_core_model_i (.clk_o(peripheral_core_clock_i),
    .val_o(core_rsync_val_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // One whole bus request; n counts cycles until the answer
  task automatic acc(input logic w, input logic [2:0] i, input logic [31:0] d,
                     output logic [31:0] q, output int n);
    n = 0;
    @(posedge sys_clk_i); #1;
    bus_req_i = 1'b1;
    bus_cmd_i = '{write: w, index: i, wdata: d};
    do begin
      @(posedge sys_clk_i); #1;
      n++;
    end while (bus_ready_o !== 1'b1 && n < 300);
    if (bus_ready_o !== 1'b1) num_errors++;
    // Hold the request through the edge that samples ready high
    @(posedge sys_clk_i); #1;
    q = bus_rdata_o;
    bus_req_i = 1'b0;
  endtask
  task automatic idle(output int c);
    c = 0;
    while (sync_in_progress_o !== 1'b0 && c < 300) begin
      @(posedge sys_clk_i); #1;
      c++;
    end
    if (sync_in_progress_o !== 1'b0) num_errors++;
  endtask
  task automatic t_write();
    logic [31:0] q;
    int n;
    acc(1'b1, 3'h1, 32'h0bad_f00d, q, n);
    `CHK(n, 1)
    `CHK(core_reg_o[1], 32'h0bad_f00d)
    acc(1'b1, 3'h3, 32'hc0de_0003, q, n);
    `CHK(n, 1)
    `CHK(sync_in_progress_o, 1'b1)
    acc(1'b0, 3'h4, 32'h0, q, n);
    `CHK(n, 1)
    `CHK(q, REG_RESET_VAL)
    acc(1'b0, 3'h1, 32'h0, q, n);
    `CHK(n, 1)
    `CHK(q, 32'h0bad_f00d)
    acc(1'b0, 3'h3, 32'h0, q, n);
    `CHK(n > 1, 1'b1)
    `CHK(q, 32'hc0de_0003)
    $display("test t_write done");
  endtask
  task automatic t_queue();
    logic [31:0] q;
    int n;
    acc(1'b1, 3'h2, 32'h2222_0002, q, n);
    acc(1'b1, 3'h5, 32'h5555_0005, q, n);
    `CHK(n > 1, 1'b1)
    `CHK(core_reg_o[2], 32'h2222_0002)
    idle(n);
    `CHK(n >= 5*CP-1 && n <= 6*CP+3, 1'b1)
    `CHK(core_reg_o[5], 32'h5555_0005)
    $display("test t_queue done");
  endtask
  task automatic t_rsync();
    logic [31:0] q;
    int n;
    acc(1'b0, 3'h6, 32'h0, q, n);
    `CHK(n > 5*CP, 1'b1)
    `CHK(q, V6)
    acc(1'b0, 3'h7, 32'h0, q, ns);
    `CHK(q, V7)
    `CHK(sync_in_progress_o, 1'b0)
    acc(1'b1, 3'h2, 32'h2222_00f2, q, n);
    acc(1'b0, 3'h7, 32'h0, q, n);
    `CHK(n > 2*5*CP && n > ns + 2*CP, 1'b1)
    `CHK(q, V7)
    $display("test t_rsync done");
  endtask
  task automatic results();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    rst_b_i = 1'b0;
    bus_req_i = 1'b0;
    bus_cmd_i = '0;
    repeat (20) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    for (int k = 0; k < NUM_REGS; k++) begin
      `CHK(core_reg_o[k], REG_RESET_VAL)
    end
    t_write();
    t_queue();
    t_rsync();
    results();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
